/* src/spi_port.sv */
// serial peripheral port, master or slave, with apb register access and
// halt/wait low-power hooks.
// assumes pin inputs already synchronous to CLK_SYS; the pad logic resolves
// each pin from its *_OE_N enable.
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// R1: irq output is enable bit and (done or mode fault or overrun)
// R2: port enable resets to 0; when set, pins take serial functions
// R3: select low in master mode clears port enable and master select
// R4: master drives clock and outgoing data; slave takes clock, returns data
// R5: idle level bit sets clock idle level; software disables before change
// R6: phase 0 captures on first transition, phase 1 on second
// R7: master rate from divider-disable and rate bits; ignored as slave
// R8: done flag set on byte end; cleared by csr access then data access
// R9: data writes ignored while done flag set until csr read; code also lifts this on a csr write
// R10: collision flag set by data write mid-transfer; no interrupt
// R11: overrun set when byte ends while done still set; csr read clears
// R12: mode fault set by select low as master; csr read then ctrl write
// R13: output disable bit removes outgoing data drive
// R14: select source bit picks software level instead of select pin
// R15: software writes 0 to reserved csr bit; reads back 0
// R16: in wait the port runs; its interrupt wakes the core
// R17: in halt registers freeze and port is inactive
// R18: slave done flag may wake from halt; faults and overrun cannot
// R19: several bytes before done is cleared set overrun, first byte kept
// R20: halt wake only if select was low when halt entered
// R21: after wake, leaving slave mode restores normal state at once
// R22: master enables at most one slave at a time
// R23: with software select, level 0 selects and 1 deselects
// R24: byte copied to read buffer at transfer end; reads return buffer
// R25: master data write loads shifter and starts; msb first
module spi_port
  import spi_port_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // system
  input  wire logic              CLK_SYS,
  input  wire logic              RSTN,
  // apb slave
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [ADDR_W-1:0] PADDR,
  input  wire logic [31:0]       PWDATA,
  output logic      [31:0]       PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  // serial clock pin
  input  wire logic              SCK_IN,
  output logic                   SCK_OUT,
  output logic                   SCK_OE_N,
  // master-out data pin
  input  wire logic              MOSI_IN,
  output logic                   MOSI_OUT,
  output logic                   MOSI_OE_N,
  // master-in data pin
  input  wire logic              MISO_IN,
  output logic                   MISO_OUT,
  output logic                   MISO_OE_N,
  // slave select pin and pin ownership
  input  wire logic              SS_N_IN,
  output logic                   SS_PIN_USED,
  output logic                   PINS_ACTIVE,
  // interrupt and low power
  input  wire logic              HALT_REQ,
  output logic                   IRQ,
  output logic                   WAKE_HALT
);

  // the decoder compares the low ten address bits and needs the rest zero
  if (ADDR_W < 10) begin : g_addr_check
    $error("ADDR_W must be at least 10");
  end

  // ==========================================================================
  // state
  typedef enum logic [0:0] {ENG_IDLE, ENG_SHIFT} eng_t;

  typedef struct packed {
    eng_t        st;
    logic [7:0]  ctrl;
    logic        done;
    logic        write_collision_flag;
    logic        overrun_flag;
    logic        mode_fault_flag;
    logic [2:0]  csr_lo;
    logic        done_seen;
    logic        write_collision_flag_seen;
    logic        mode_fault_flag_seen;
    logic [7:0]  shift;
    logic        dout;
    logic [7:0]  rxbuf;
    logic        latch;
    logic [4:0]  edges;
    logic [4:0]  divcnt;
    logic        ph;
    logic        sck_prev;
    logic        halt_prev;
    logic        armed;
    logic [31:0] prdata;
  } state_t;

  state_t r;
  state_t n;

  function automatic logic [4:0] half_period(input logic [2:0] code);
    case (code)
      3'h4:    half_period = HALF_DIV2;
      3'h0:    half_period = HALF_DIV4;
      3'h1:    half_period = HALF_DIV8;
      3'h6:    half_period = HALF_DIV16;
      3'h2:    half_period = HALF_DIV32;
      default: half_period = HALF_DIV64;
    endcase
  endfunction

  // ==========================================================================
  // decode
  logic       port_en;
  logic       master_select_bit;
  logic       phase_bit;
  logic       ss_int_n;
  logic       slave_sel;
  logic       edge_ev;
  logic       din;
  logic       sample;
  logic [7:0] byte_in;
  logic       apb_setup;
  logic       apb_wr;
  logic       apb_rd;
  logic       hit_data;
  logic       hit_ctrl;
  logic       hit_csr;
  logic       freeze;

  assign port_en   = r.ctrl[CTRL_PORT_EN];
  assign master_select_bit      = r.ctrl[CTRL_MASTER_SELECT_BIT];
  assign phase_bit      = r.ctrl[CTRL_PHASE];
  assign ss_int_n  = r.csr_lo[CSR_SSM] ? r.csr_lo[CSR_SSI] : SS_N_IN; // [R14] [R23]
  assign slave_sel = port_en & ~master_select_bit & ~ss_int_n;
  assign din       = master_select_bit ? MISO_IN : MOSI_IN;
  assign sample    = (r.edges[0] == phase_bit);                        // [R6]
  assign apb_setup = PSEL & ~PENABLE;
  assign apb_wr    = PSEL & PENABLE & PWRITE;
  assign apb_rd    = PSEL & PENABLE & ~PWRITE;
  assign hit_data  = (PADDR[9:0] == ADDR_DATA) && (PADDR >> 10) == '0;
  assign hit_ctrl  = (PADDR[9:0] == ADDR_CTRL) && (PADDR >> 10) == '0;
  assign hit_csr   = (PADDR[9:0] == ADDR_CSR) && (PADDR >> 10) == '0;
  // a halted core stops the port unless a slave wake-up was armed
  assign freeze    = HALT_REQ & ~r.armed;                         // [R17]

  // master: divider expiry; slave: any transition on the clock pin while selected [R7]
  always_comb begin
    if (master_select_bit) begin
      edge_ev = port_en && r.st == ENG_SHIFT &&
                r.divcnt == half_period({r.ctrl[CTRL_DIV_DIS],
                                         r.ctrl[CTRL_RATE_HI:CTRL_RATE_LO]});
    end else begin
      edge_ev = slave_sel & (SCK_IN != r.sck_prev);
    end
  end

  // phase 1 takes the last bit straight from the pin on the final edge
  assign byte_in = phase_bit ? {r.shift[6:0], din} : {r.shift[6:0], r.latch};

  // read word, built apart from the next state so that a frozen port
  // still answers reads with its held contents
  logic [31:0] rd_word;

  always_comb begin
    if (hit_data) begin
      rd_word = {24'h000000, r.rxbuf};                            // [R24]
    end else if (hit_ctrl) begin
      rd_word = {24'h000000, r.ctrl};
    end else if (hit_csr) begin
      rd_word = {24'h000000, r.done, r.write_collision_flag, r.overrun_flag, r.mode_fault_flag,
                 1'b0, r.csr_lo};                                 // [R15]
    end else begin
      rd_word = 32'h00000000;
    end
  end

  // ==========================================================================
  // next state
  always_comb begin
    n = r;
    n.sck_prev  = SCK_IN;
    n.halt_prev = HALT_REQ;

    // ---- register reads: registered in setup, side effects in access
    if (apb_setup) begin
      n.prdata = rd_word;
    end

    if (apb_rd && hit_csr) begin
      n.done_seen = r.done_seen | r.done;                         // [R8]
      n.write_collision_flag_seen = r.write_collision_flag_seen | r.write_collision_flag;                         // [R10]
      n.mode_fault_flag_seen = r.mode_fault_flag_seen | r.mode_fault_flag;                         // [R12]
      n.overrun_flag       = 1'b0;                                         // [R11]
    end
    if (apb_wr && hit_csr) begin
      n.csr_lo    = PWDATA[2:0];
      n.done_seen = r.done_seen | r.done;                         // [R8]
    end

    if (apb_wr && hit_ctrl) begin
      n.ctrl = PWDATA[7:0];
      if (r.mode_fault_flag && r.mode_fault_flag_seen) begin
        n.mode_fault_flag      = 1'b0;                                       // [R12]
        n.mode_fault_flag_seen = 1'b0;
      end else if (r.mode_fault_flag) begin
        // enable and master stay clear until the fault is acknowledged
        n.ctrl[CTRL_PORT_EN] = 1'b0;
        n.ctrl[CTRL_MASTER_SELECT_BIT]    = 1'b0;
      end
    end

    if ((apb_rd || apb_wr) && hit_data && r.done_seen) begin
      n.done      = 1'b0;                                         // [R8]
      n.done_seen = 1'b0;
    end
    if (apb_rd && hit_data && r.write_collision_flag_seen) begin
      n.write_collision_flag      = 1'b0;                                         // [R10]
      n.write_collision_flag_seen = 1'b0;
    end

    if (apb_wr && hit_data && !(r.done && !r.done_seen)) begin   // [R9]
      if (r.st == ENG_SHIFT) begin
        n.write_collision_flag = 1'b1;                                            // [R10]
      end else begin
        n.shift = PWDATA[7:0];                                    // [R25]
        n.dout  = PWDATA[7];
        if (master_select_bit && port_en) begin
          n.st     = ENG_SHIFT;                                   // [R25]
          n.edges  = 5'h00;
          n.divcnt = 5'h00;
          n.ph     = 1'b0;
        end
      end
    end

    // ---- shift engine
    if (master_select_bit && r.st == ENG_SHIFT) begin
      n.divcnt = edge_ev ? 5'h00 : r.divcnt + 5'h01;
    end
    if (edge_ev) begin
      n.st    = ENG_SHIFT;
      n.ph    = ~r.ph;
      n.edges = r.edges + 5'h01;
      if (sample) begin
        n.latch = din;                                            // [R6]
      end else if (!(phase_bit && r.edges == 5'h00)) begin
        n.shift = {r.shift[6:0], r.latch};                        // [R25]
        n.dout  = r.shift[6];
      end else begin
        // phase 1: the first transition only presents the msb
        n.dout  = r.shift[7];
      end
      if (r.edges == EDGES_LAST) begin
        n.st    = ENG_IDLE;
        n.edges = 5'h00;
        n.ph    = 1'b0;
        n.shift = byte_in;
        if (r.done && n.done) begin
          n.overrun_flag = 1'b1;                                           // [R11] [R19]
        end else begin
          n.rxbuf = byte_in;                                      // [R24]
        end
        n.done      = 1'b1;                                       // [R8]
        n.done_seen = 1'b0;
      end
    end

    // a slave losing its select or enable drops the partial byte
    if (!master_select_bit && (ss_int_n || !port_en)) begin
      n.st    = ENG_IDLE;
      n.edges = 5'h00;
    end
    if (master_select_bit && !port_en) begin
      n.st = ENG_IDLE;
      n.ph = 1'b0;
    end

    // ---- mode fault
    if (master_select_bit && port_en && !ss_int_n) begin
      n.mode_fault_flag                 = 1'b1;                              // [R12]
      n.mode_fault_flag_seen            = 1'b0;
      n.ctrl[CTRL_PORT_EN]   = 1'b0;                              // [R3]
      n.ctrl[CTRL_MASTER_SELECT_BIT]      = 1'b0;                              // [R3]
      n.st                   = ENG_IDLE;
      n.ph                   = 1'b0;
      n.edges                = 5'h00;
    end

    // ---- halt: arm a wake-up only for a selected, enabled slave
    if (HALT_REQ && !r.halt_prev) begin
      n.armed = port_en & ~master_select_bit & ~ss_int_n;                      // [R20]
    end else if (!HALT_REQ) begin
      n.armed = 1'b0;                                             // [R21]
    end
    if (freeze) begin
      n           = r;                                            // [R17]
      n.sck_prev  = SCK_IN;
      n.halt_prev = HALT_REQ;
      if (apb_setup) begin
        n.prdata = rd_word;
      end
      if (HALT_REQ && !r.halt_prev) begin
        n.armed = port_en & ~master_select_bit & ~ss_int_n;                    // [R20]
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      r <= '{st: ENG_IDLE, ctrl: CTRL_RESET, done: 1'b0, write_collision_flag: 1'b0,
             overrun_flag: 1'b0, mode_fault_flag: 1'b0, csr_lo: CSR_LO_RESET,
             done_seen: 1'b0, write_collision_flag_seen: 1'b0, mode_fault_flag_seen: 1'b0,
             shift: DATA_RESET, dout: 1'b0, rxbuf: DATA_RESET, latch: 1'b0,
             edges: 5'h00, divcnt: 5'h00, ph: 1'b0, sck_prev: 1'b0,
             halt_prev: 1'b0, armed: 1'b0, prdata: 32'h00000000};
    end else begin
      r <= n;
    end
  end

  // ==========================================================================
  // outputs
  assign PRDATA    = r.prdata;
  assign PREADY    = 1'b1;
  assign PSLVERR   = PSEL & PENABLE & ~(hit_data | hit_ctrl | hit_csr);

  assign PINS_ACTIVE = port_en;                                   // [R2]
  assign SS_PIN_USED = port_en & ~r.csr_lo[CSR_SSM];              // [R14]
  // clock rests at the idle level; ph counts transitions away from it
  assign SCK_OUT   = r.ctrl[CTRL_IDLE] ^ r.ph;                    // [R5]
  assign SCK_OE_N  = ~(port_en & master_select_bit);                           // [R4]
  // the data bit moves only on data writes and non-capture transitions, so the byte-end load
  // of the shifter cannot disturb the final capture edge of phase 1
  assign MOSI_OUT  = r.dout;                                      // [R25]
  assign MOSI_OE_N = ~(port_en & master_select_bit & ~r.csr_lo[CSR_SOD]);      // [R4] [R13]
  assign MISO_OUT  = r.dout;
  // a deselected slave releases the return line so others may drive it
  assign MISO_OE_N = ~(slave_sel & ~r.csr_lo[CSR_SOD]);           // [R13] [R22]

  // the same request wakes the core from wait [R16]
  assign IRQ       = r.ctrl[CTRL_IRQ_EN] & (r.done | r.mode_fault_flag | r.overrun_flag); // [R1]
  assign WAKE_HALT = HALT_REQ & r.armed & r.done & r.ctrl[CTRL_IRQ_EN]; // [R18]

endmodule // spi_port

`default_nettype wire

/* src/spi_port_pkg.sv */
// constants for the synchronous serial port: register map, field positions,
// reset values and the master clock divider table.
// assumes a 32-bit apb bus with word-aligned registers.
package spi_port_pkg;

  // ==========================================================================
  // register indices and byte addresses (byte address = 4 * index)
  localparam logic [7:0] IDX_DATA = 8'h19;
  localparam logic [7:0] IDX_CTRL = 8'h1a;
  localparam logic [7:0] IDX_CSR  = 8'h1b;
  localparam logic [9:0] ADDR_DATA = {IDX_DATA, 2'b00};
  localparam logic [9:0] ADDR_CTRL = {IDX_CTRL, 2'b00};
  localparam logic [9:0] ADDR_CSR  = {IDX_CSR, 2'b00};

  // ==========================================================================
  // control register fields
  localparam int CTRL_IRQ_EN   = 7;
  localparam int CTRL_PORT_EN  = 6;
  localparam int CTRL_DIV_DIS  = 5;
  localparam int CTRL_MASTER_SELECT_BIT     = 4;
  localparam int CTRL_IDLE     = 3;
  localparam int CTRL_PHASE    = 2;
  localparam int CTRL_RATE_HI  = 1;
  localparam int CTRL_RATE_LO  = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // ==========================================================================
  // control/status register fields
  localparam int CSR_DONE     = 7;
  localparam int CSR_WRITE_COLLISION_FLAG     = 6;
  localparam int CSR_OVR      = 5;
  localparam int CSR_MODE_FAULT_FLAG     = 4;
  localparam int CSR_RSVD     = 3;
  localparam int CSR_SOD      = 2;
  localparam int CSR_SSM      = 1;
  localparam int CSR_SSI      = 0;
  localparam logic [2:0] CSR_LO_RESET = 3'h0;
  localparam logic [7:0] DATA_RESET   = 8'h00;

  // ==========================================================================
  // serial timing: a byte is sixteen clock transitions
  localparam logic [4:0] EDGES_LAST = 5'h0f;

  // half periods of the serial clock less one, in core cycles, per {div_dis, rate}
  localparam logic [4:0] HALF_DIV2  = 5'h00;
  localparam logic [4:0] HALF_DIV4  = 5'h01;
  localparam logic [4:0] HALF_DIV8  = 5'h03;
  localparam logic [4:0] HALF_DIV16 = 5'h07;
  localparam logic [4:0] HALF_DIV32 = 5'h0f;
  localparam logic [4:0] HALF_DIV64 = 5'h1f;

endpackage

/* verification/spi_port_props.sv */
// checker for spi_port: pin ownership, mode fault drop, halt freeze.
// assumes it is bound to spi_port and sees its ports only.
`timescale 1ns/1ns
`default_nettype none
module spi_port_props (
  // system
  input wire logic CLK_SYS,
  input wire logic RSTN,
  // pins
  input wire logic SCK_OUT,
  input wire logic SCK_OE_N,
  input wire logic MOSI_OE_N,
  input wire logic MISO_OE_N,
  input wire logic SS_N_IN,
  input wire logic SS_PIN_USED,
  input wire logic PINS_ACTIVE,
  // low power
  input wire logic HALT_REQ,
  input wire logic IRQ,
  input wire logic WAKE_HALT
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);

  // ==========================================================================
  // pin ownership
  pins_released_a: assert property (!PINS_ACTIVE |->
    SCK_OE_N && MOSI_OE_N && MISO_OE_N) else $error("pin driven while off");
  master_pins_a: assert property (!SCK_OE_N |->
    PINS_ACTIVE && MISO_OE_N) else $error("master pin roles wrong");
  slave_return_a: assert property (!MISO_OE_N |->
    PINS_ACTIVE && SCK_OE_N) else $error("return line driven as master");
  master_out_a: assert property (!MOSI_OE_N |-> !SCK_OE_N)
    else $error("outgoing line driven as slave");
  pin_select_a: assert property (SS_PIN_USED |-> PINS_ACTIVE)
    else $error("select pin taken while port off");

  // ==========================================================================
  // mode fault and halt
  fault_drop_a: assert property (!SCK_OE_N && SS_PIN_USED &&
    !SS_N_IN && !HALT_REQ |=> !PINS_ACTIVE && SCK_OE_N)
    else $error("master kept pins with select low");
  halt_freeze_a: assert property (HALT_REQ && $past(HALT_REQ) &&
    !SCK_OE_N |=> $stable(SCK_OUT) && !SCK_OE_N)
    else $error("master moved during halt");
  master_no_wake_a: assert property (HALT_REQ && !SCK_OE_N
    |-> !WAKE_HALT) else $error("master woke the core");

  fault_c: cover property (!SS_N_IN && SS_PIN_USED && !SCK_OE_N);
  halt_c: cover property (HALT_REQ && !SCK_OE_N);
  slave_c: cover property (!MISO_OE_N);
  irq_c: cover property ($rose(IRQ));
endmodule // spi_port_props

bind spi_port spi_port_props props_i (
  .CLK_SYS     (CLK_SYS),
  .RSTN        (RSTN),
  .SCK_OUT     (SCK_OUT),
  .SCK_OE_N    (SCK_OE_N),
  .MOSI_OE_N   (MOSI_OE_N),
  .MISO_OE_N   (MISO_OE_N),
  .SS_N_IN     (SS_N_IN),
  .SS_PIN_USED (SS_PIN_USED),
  .PINS_ACTIVE (PINS_ACTIVE),
  .HALT_REQ    (HALT_REQ),
  .IRQ         (IRQ),
  .WAKE_HALT   (WAKE_HALT)
);
`default_nettype wire

/* verification/spi_slave_model.sv */
// behavioural far-end slave: swaps one byte with the port, msb first.
// assumes the bench selects it and hands it the port's phase setting.
`timescale 1ns/1ns
`default_nettype none
module spi_slave_model (
  // serial lines
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       sel_n,
  output logic            miso,
  // settings and data
  input  wire logic       phase_bit,
  input  wire logic [7:0] tx,
  output logic      [7:0] rx
);
  logic [7:0] sh;
  int         n;
  initial miso = 1'b0;
  initial rx = 8'h00;
  // no pull on the line, so a released line flips instead of holding
  always @(posedge sel_n) miso = ~miso;
  always @(negedge sel_n) begin
    sh = tx;
    n = 0;
    miso = tx[7];
  end
  always @(sck) begin
    if (!sel_n) begin
      n++;
      if (n[0] ^ phase_bit) begin
        rx = {rx[6:0], mosi};
      end else if (n > 1) begin
        sh = sh << 1;
        miso = sh[7];
      end
    end
  end
endmodule // spi_slave_model
`default_nettype wire

/* verification/tb_spi_port.sv */
// self-checking bench for spi_port: registers, master bytes at every rate,
// faults, select modes, output disable and halt freeze.
// assumes the far-end model and the checker are compiled alongside.
`timescale 1ns/1ns
`default_nettype none
module tb_spi_port
  import spi_port_pkg::*;
;
  logic        CLK_SYS = 1'b0;
  logic        RSTN = 1'b0;
  logic        PSEL = 1'b0;
  logic        PENABLE = 1'b0;
  logic        PWRITE = 1'b0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0;
  logic [31:0] PRDATA;
  logic        PREADY, PSLVERR, SCK_IN, SCK_OUT, SCK_OE_N;
  logic        MOSI_IN, MOSI_OUT, MOSI_OE_N, MISO_IN, MISO_OUT, MISO_OE_N;
  logic        SS_N_IN = 1'b1;
  logic        HALT_REQ = 1'b0;
  logic        ext_sck = 1'b0;
  logic        SS_PIN_USED, PINS_ACTIVE, IRQ, WAKE_HALT;
  logic        pm_miso, perr;
  logic        pm_sel_n = 1'b1;
  logic        pm_phase_bit = 1'b0;
  logic [7:0]  pm_tx = 8'h00;
  logic [7:0]  pm_rx, cfg, tx;
  logic [31:0] q;
  int          n, n_errors, checks_done;
  logic [2:0]  codes [6] = '{3'b100, 3'b000, 3'b001, 3'b110, 3'b010, 3'b011};

  always #20 CLK_SYS = ~CLK_SYS;
  // bench clock rests low while the port does not drive; undriven data flips
  assign SCK_IN  = SCK_OE_N ? ext_sck : SCK_OUT;
  assign MOSI_IN = MOSI_OE_N ? ~MOSI_OUT : MOSI_OUT;
  assign MISO_IN = MISO_OE_N ? pm_miso : MISO_OUT;

  spi_slave_model far_end (
    .sck  (SCK_IN),
    .mosi (MOSI_IN),
    .sel_n(pm_sel_n),
    .miso (pm_miso),
    .phase_bit (pm_phase_bit),
    .tx   (pm_tx),
    .rx   (pm_rx)
  );
  spi_port DUT (
    .CLK_SYS     (CLK_SYS),
    .RSTN        (RSTN),
    .PSEL        (PSEL),
    .PENABLE     (PENABLE),
    .PWRITE      (PWRITE),
    .PADDR       (PADDR),
    .PWDATA      (PWDATA),
    .PRDATA      (PRDATA),
    .PREADY      (PREADY),
    .PSLVERR     (PSLVERR),
    .SCK_IN      (SCK_IN),
    .SCK_OUT     (SCK_OUT),
    .SCK_OE_N    (SCK_OE_N),
    .MOSI_IN     (MOSI_IN),
    .MOSI_OUT    (MOSI_OUT),
    .MOSI_OE_N   (MOSI_OE_N),
    .MISO_IN     (MISO_IN),
    .MISO_OUT    (MISO_OUT),
    .MISO_OE_N   (MISO_OE_N),
    .SS_N_IN     (SS_N_IN),
    .SS_PIN_USED (SS_PIN_USED),
    .PINS_ACTIVE (PINS_ACTIVE),
    .HALT_REQ    (HALT_REQ),
    .IRQ         (IRQ),
    .WAKE_HALT   (WAKE_HALT)
  );

  // ==========================================================================
  // helpers
  function automatic int cyc(input int i);
    return 16 * (1 << i);
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge CLK_SYS);
    #1;
  endtask

  task automatic apb(input logic w, input logic [9:0] a, input logic [7:0] d);
    @(posedge CLK_SYS);
    PSEL   <= 1'b1;
    PWRITE <= w;
    PADDR  <= {2'b00, a};
    PWDATA <= {24'h000000, d};
    @(posedge CLK_SYS);
    PENABLE <= 1'b1;
    do @(posedge CLK_SYS); while (PREADY !== 1'b1);
    q = PRDATA;
    perr = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
    #1;
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    apb(1'b0, a, 8'h00);
    chk(q, e);
  endtask

  task automatic print_verdict;
    $display("checks %0d, errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #(40 * 20000);
    n_errors++;
    print_verdict;
  end

  // ==========================================================================
  // main sequence
  initial begin
    void'($urandom(32'hc4eb4c24));
    tick(16);
    @(posedge CLK_SYS) RSTN <= 1'b1;
    rd(ADDR_CTRL, CTRL_RESET);
    rd(ADDR_CSR, 32'h0);
    rd(ADDR_DATA, DATA_RESET);
    rd(10'h000, 32'h0);
    chk(perr, 1'b1);
    // reserved csr bit always written as 0
    wr(ADDR_CSR, 8'h02);
    wr(ADDR_CTRL, 8'h40);
    chk({MISO_OE_N, SCK_OE_N, PINS_ACTIVE}, 3'b011);
    wr(ADDR_CSR, 8'h03);
    chk(MISO_OE_N, 1'b1);
    wr(ADDR_CTRL, 8'h00);
    for (int k = 0; k < 2; k++) begin
      wr(ADDR_CTRL, 8'hd0);
      chk({PINS_ACTIVE, SCK_OE_N}, 2'b10);
      wr(ADDR_CSR, k ? 8'h02 : 8'h00);
      if (k == 0) @(posedge CLK_SYS) SS_N_IN <= 1'b0;
      tick(2);
      chk({PINS_ACTIVE, IRQ}, 2'b01);
      rd(ADDR_CSR, k ? 32'h12 : 32'h10);
      rd(ADDR_CTRL, 32'h80);
      @(posedge CLK_SYS) SS_N_IN <= 1'b1;
      wr(ADDR_CSR, 8'h03);
      wr(ADDR_CTRL, 8'h00);
      rd(ADDR_CSR, 32'h03);
    end
    // ========================================================================
    // one byte per rate code, all four idle/phase pairs
    for (int i = 0; i < 6; i++) begin
      cfg = {2'b11, codes[i][2], 1'b1, i[1:0], codes[i][1:0]};
      wr(ADDR_CTRL, 8'h00);
      wr(ADDR_CTRL, cfg);
      chk({SCK_OUT, MOSI_OE_N}, {i[1], 1'b0});
      tx = 8'($urandom);
      pm_tx = 8'($urandom);
      pm_phase_bit = i[0];
      pm_sel_n = 1'b0;
      wr(ADDR_DATA, tx);
      n = 0;
      do begin
        tick(1);
        n++;
      end while (IRQ !== 1'b1 && n < 5000);
      chk(n, cyc(i));
      chk(pm_rx, tx);
      wr(ADDR_DATA, 8'h5a);
      tick(cyc(i) + 2);
      rd(ADDR_CSR, 32'h83);
      wr(ADDR_CTRL, cfg & 8'h7f);
      chk(IRQ, 1'b0);
      rd(ADDR_DATA, pm_tx);
      rd(ADDR_CSR, 32'h03);
      pm_sel_n = 1'b1;
    end
    // ========================================================================
    // collision, output disable, halt
    wr(ADDR_CTRL, cfg);
    pm_sel_n = 1'b0;
    wr(ADDR_DATA, 8'($urandom));
    wr(ADDR_DATA, 8'h00);
    rd(ADDR_CSR, 32'h43);
    chk(IRQ, 1'b0);
    tick(cyc(5));
    rd(ADDR_CSR, 32'hc3);
    rd(ADDR_DATA, pm_tx);
    rd(ADDR_CSR, 32'h03);
    pm_sel_n = 1'b1;
    wr(ADDR_CSR, 8'h07);
    chk(MOSI_OE_N, 1'b1);
    wr(ADDR_CSR, 8'h03);
    @(posedge CLK_SYS) HALT_REQ <= 1'b1;
    wr(ADDR_CTRL, 8'h00);
    rd(ADDR_CTRL, cfg);
    chk(WAKE_HALT, 1'b0);
    @(posedge CLK_SYS) HALT_REQ <= 1'b0;
    wr(ADDR_CTRL, 8'h00);
    rd(ADDR_CTRL, 32'h00);
    // slave: two bytes with no clear between, halt wake-up armed
    wr(ADDR_CSR, 8'h02);
    wr(ADDR_CTRL, 8'hc0);
    @(posedge CLK_SYS) HALT_REQ <= 1'b1;
    repeat (32) begin
      @(posedge CLK_SYS) ext_sck <= ~ext_sck;
      @(posedge CLK_SYS);
    end
    tick(2);
    chk(WAKE_HALT, 1'b1);
    @(posedge CLK_SYS) HALT_REQ <= 1'b0;
    rd(ADDR_CSR, 32'ha2);
    chk(IRQ, 1'b1);
    rd(ADDR_CSR, 32'h82);
    print_verdict;
  end
endmodule // tb_spi_port
`default_nettype wire
